//--- hdl/pdm_cnt_if.sv
// Carrier between the pulse controller and its division counter.
// Assumes both ends share sys_clk.
`timescale 1ns/1ns
interface pdm_cnt_if;
	import pdm_pkg::*;
	logic hardClr;
	logic clear;
	logic tick;
	logic splitMode;
	logic [EXP_W-1:0] ratioExp;
	logic terminal;
	logic [COUNT_W-1:0] count;

	modport ctrl (output hardClr, output clear, output tick, output splitMode,
		output ratioExp, input terminal, input count);
	modport cnt (input hardClr, input clear, input tick, input splitMode,
		input ratioExp, output terminal, output count);
endinterface

//--- hdl/pdm_counter.sv
// Twenty-four stage division counter, splittable into three 8-stage sections.
// Assumes the controller gates ticks and holds clear over tick.
`timescale 1ns/1ns
module pdm_counter #(
	parameter int COUNT_BITS = pdm_pkg::COUNT_W,
	parameter int SECT_BITS = pdm_pkg::SECT_W
) (
	// Clock
	input wire logic sys_clk,
	// Controller side
	pdm_cnt_if.cnt ifc
);
	import pdm_pkg::*;

	initial begin
		if (COUNT_BITS != 3 * SECT_BITS || COUNT_BITS != COUNT_W)
			$error("pdm_counter: width must be three sections of the package width");
	end

	pdm_cnt_state_t s;
	pdm_cnt_state_t next_s;
	logic [COUNT_W-1:0] mask;

	always_comb begin
		next_s = s;
		mask = ~(COUNT_W'(24'hffffff) << ifc.ratioExp);
		if (ifc.clear) begin
			next_s.count = COUNT_RESET;
		end else if (ifc.tick) begin
			if (ifc.splitMode) begin
				// Sections clock in parallel so a preload takes 255 ticks
				for (int i = 0; i < 3; i++)
					next_s.count[i*SECT_W +: SECT_W] = s.count[i*SECT_W +: SECT_W] + 8'h01;
			end else begin
				next_s.count = s.count + 24'h000001;
			end
		end
	end

	// Stages one tick short of the ratio; tick qualified by the controller
	// Kept free of tick so the controller's comb logic has no loop
	assign ifc.terminal = &(s.count | ~mask);
	assign ifc.count = s.count;

	always_ff @(posedge sys_clk or posedge ifc.hardClr) begin
		if (ifc.hardClr)
			s <= '{count: COUNT_RESET};
		else
			s <= next_s;
	end

endmodule // pdm_counter

//--- hdl/pdm_pkg.sv
// Constants, state types and decode helpers for the programmable delay monostable.
// Assumes a single 20 MHz system clock; all pins arrive asynchronously to it.
// How it works
// - Pulse length is counting clock divided by power
// - Rising positive trigger starts one pulse
// - Falling negative trigger starts one pulse
// - Oscillator runs always or only during pulse
// - Delay and oscillator start with output high
// - At terminal count clear stages, outputs idle
// - Power-up reset clears all stages
// - Master clear asynchronously ends pulse, blocks triggers
// - Duration is period times ratio, minimum 100ns
// - Retrigger enabled: edges during pulse extend it
// - Retrigger disabled: edges during pulse ignored
// - True output high, complement low during pulse
// - Low range splits counter into three sections
// - Preload then high range ends after one tick
package pdm_pkg;

	// ****************************************************************
	// Counter geometry and ratio decode
	// ****************************************************************
	localparam int COUNT_W = 24;
	localparam int SECT_W = 8;
	localparam int SEL_W = 3;
	localparam int EXP_W = 5;
	localparam logic [EXP_W-1:0] LOW_EXP_BASE = 5'h01;
	localparam logic [EXP_W-1:0] HIGH_EXP_BASE = 5'h11;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_FREQ_MHZ = 20;
	localparam int MIN_PULSE_NS = 100;
	localparam int MIN_PULSE_CYC_RAW = (MIN_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_CYC_RAW < 1) ? 1 : MIN_PULSE_CYC_RAW;
	localparam int MIN_CNT_W = 3;
	localparam logic [MIN_CNT_W-1:0] MIN_CNT_LAST = MIN_CNT_W'(MIN_PULSE_CYC - 1);

	// ****************************************************************
	// Synchronised configuration bit positions
	// ****************************************************************
	localparam int CFG_W = 6;
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_RANGE = 3;
	localparam int CFG_RETRIG = 4;
	localparam int CFG_OSC_RUN = 5;

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef enum logic [0:0] {
		PDM_IDLE,
		PDM_TIMING
	} pdm_phase_t;

	typedef struct packed {
		pdm_phase_t phase;
		logic pulseOut;
		logic pulseOutN;
		logic oscEnable;
		logic [1:0] posSync;
		logic [1:0] negSync;
		logic [1:0] clkSync;
		logic [1:0][CFG_W-1:0] cfgSync;
		logic posLast;
		logic negLast;
		logic clkLast;
		logic [MIN_CNT_W-1:0] minCnt;
		logic endSeen;
	} pdm_state_t;

	typedef struct packed {
		logic [COUNT_W-1:0] count;
	} pdm_cnt_state_t;

	// Exponent of the division ratio from the select lines
	function automatic logic [EXP_W-1:0] pdm_ratio_exp(input logic highRange,
		input logic [SEL_W-1:0] sel);
		pdm_ratio_exp = (highRange ? HIGH_EXP_BASE : LOW_EXP_BASE) + EXP_W'(sel);
	endfunction

	// Rising edge of a synchronised level against its last sample
	function automatic logic pdm_rise(input logic now, input logic last);
		pdm_rise = now & ~last;
	endfunction

endpackage

//--- hdl/pdm_timer.sv
// Top of the programmable delay monostable: triggers, pulse control, oscillator gating.
// Assumes every pin input is asynchronous to sys_clk; all but sys_rst and master_clear are synchronised here.
`timescale 1ns/1ns
module pdm_timer #(
	parameter int MIN_CYCLES = pdm_pkg::MIN_PULSE_CYC
) (
	// Clock and power-on reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Counting clock pin
	input wire logic clock_osc_in,
	// Triggers
	input wire logic trigPos,
	input wire logic trigNeg,
	// Mode and ratio selection
	input wire logic retrigger_sel,
	input wire logic osc_run_sel,
	input wire logic range_sel,
	input wire logic ratio_sel_0,
	input wire logic ratio_sel_1,
	input wire logic ratio_sel_2,
	// Overriding clear
	input wire logic master_clear,
	// Outputs
	output logic pulseOut,
	output logic pulseOutN,
	output logic oscEnable,
	output logic [pdm_pkg::COUNT_W-1:0] countValue
);
	import pdm_pkg::*;

	initial begin
		if (MIN_CYCLES < 1 || MIN_CYCLES > (1 << MIN_CNT_W))
			$error("pdm_timer: minimum pulse cycles out of range of its counter");
	end

	// ****************************************************************
	// State and counter link
	// ****************************************************************
	localparam logic [MIN_CNT_W-1:0] MIN_LAST = MIN_CNT_W'(MIN_CYCLES - 1);

	pdm_state_t s;
	pdm_state_t next_s;
	pdm_cnt_if cif ();

	logic hardClr;
	logic [CFG_W-1:0] cfg;
	logic posEdge;
	logic negEdge;
	logic clkEdge;
	logic trigger;
	logic minDone;

	// Master clear overrides asynchronously; release is not synchronised
	assign hardClr = sys_rst | master_clear;

	assign cfg = s.cfgSync[1];
	// Edges only on the second synchroniser stage
	assign posEdge = pdm_rise(s.posSync[1], s.posLast);
	assign negEdge = pdm_rise(s.negLast, s.negSync[1]);
	// Both inputs tied together give dual-edge triggering
	assign trigger = posEdge | negEdge;
	// External clock or oscillator arrives on one pin
	assign clkEdge = pdm_rise(s.clkSync[1], s.clkLast);
	assign minDone = (s.minCnt >= MIN_LAST);

	assign cif.hardClr = hardClr;
	assign cif.splitMode = ~cfg[CFG_RANGE];
	assign cif.ratioExp = pdm_ratio_exp(cfg[CFG_RANGE], cfg[CFG_SEL_LSB +: SEL_W]);

	pdm_counter #(
		.COUNT_BITS(COUNT_W),
		.SECT_BITS(SECT_W)
	) u_counter (
		.sys_clk(sys_clk),
		.ifc(cif.cnt)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		next_s = s;
		cif.clear = 1'b0;
		cif.tick = 1'b0;

		next_s.posSync = {s.posSync[0], trigPos};
		next_s.negSync = {s.negSync[0], trigNeg};
		next_s.clkSync = {s.clkSync[0], clock_osc_in};
		next_s.cfgSync[0] = {osc_run_sel, retrigger_sel, range_sel,
			ratio_sel_2, ratio_sel_1, ratio_sel_0};
		next_s.cfgSync[1] = s.cfgSync[0];
		next_s.posLast = s.posSync[1];
		next_s.negLast = s.negSync[1];
		next_s.clkLast = s.clkSync[1];

		unique case (s.phase)
			PDM_IDLE: begin
				if (trigger) begin
					// Delay starts as the true output rises
					next_s.phase = PDM_TIMING;
					next_s.minCnt = '0;
					next_s.endSeen = 1'b0;
					cif.clear = 1'b1;
				end
			end
			PDM_TIMING: begin
				// Stop counting once the ratio is met, waiting out the floor
				cif.tick = clkEdge & ~s.endSeen;
				if (!minDone)
					next_s.minCnt = s.minCnt + 3'h1;
				if (cif.tick && cif.terminal)
					next_s.endSeen = 1'b1;
				if (trigger && cfg[CFG_RETRIG]) begin
					// Restart beats a coincident terminal count
					next_s.minCnt = '0;
					next_s.endSeen = 1'b0;
					cif.clear = 1'b1;
					cif.tick = 1'b0;
				end else if ((s.endSeen || (cif.tick && cif.terminal)) && minDone) begin
					// Floor of 100 ns holds even at the smallest ratio
					next_s.phase = PDM_IDLE;
					cif.clear = 1'b1;
				end
				// Without retrigger, edges here change nothing
			end
		endcase

		next_s.pulseOut = (next_s.phase == PDM_TIMING);
		next_s.pulseOutN = (next_s.phase != PDM_TIMING);
		// Oscillator gated off between pulses to save power unless osc_run_sel is set
		next_s.oscEnable = cfg[CFG_OSC_RUN] | (next_s.phase == PDM_TIMING);
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk or posedge hardClr) begin
		if (hardClr) begin
			// Clear leaves true output low, complement high
			s <= '{phase: PDM_IDLE, pulseOut: 1'b0, pulseOutN: 1'b1, oscEnable: 1'b0,
				posSync: 2'h0, negSync: 2'h3, clkSync: 2'h0, cfgSync: '0,
				posLast: 1'b0, negLast: 1'b1, clkLast: 1'b0, minCnt: '0,
				endSeen: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign pulseOut = s.pulseOut;
	assign pulseOutN = s.pulseOutN;
	assign oscEnable = s.oscEnable;
	assign countValue = cif.count;

endmodule // pdm_timer

//--- tb/pdm_osc_model.sv
// External oscillator standing at the counting clock pin.
// Assumes the timer gates it through oscEnable.
`timescale 1ns/1ns
module pdm_osc_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Control
	input wire logic oscEnable,
	input wire logic stall,
	// Counting clock pin
	output logic clock_osc_in
);
	logic [1:0] phase;
	// Two high, two low: the fastest shape the pin sampler still resolves
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			phase <= 2'h0;
		else if (!oscEnable)
			phase <= 2'h0;
		else if (!stall)
			phase <= phase + 2'h1;
	end
	assign clock_osc_in = phase[1];
endmodule // pdm_osc_model

//--- tb/pdm_timer_checker.sv
// Port-level checks of the delay timer.
// Assumes it is bound to every pdm_timer.
`timescale 1ns/1ns
module pdm_timer_checker #(
	parameter int MIN_CYCLES = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Pins
	input wire logic trigPos,
	input wire logic trigNeg,
	input wire logic retrigger_sel,
	input wire logic osc_run_sel,
	input wire logic master_clear,
	input wire logic pulseOut,
	input wire logic pulseOutN,
	input wire logic oscEnable,
	input wire logic [pdm_pkg::COUNT_W-1:0] countValue
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_COMPL:
	assert property (pulseOutN == !pulseOut) else $error("outputs not complementary");
	AST_CLEAR:
	assert property (master_clear |-> !pulseOut && !(|countValue)) else $error("clear ignored");
	AST_POS:
	assert property ($rose(trigPos) && !pulseOut && !master_clear ##1 (!master_clear)[*2]
		|-> ##1 pulseOut) else $error("rising trigger missed");
	AST_NEG:
	assert property ($fell(trigNeg) && !pulseOut && !master_clear ##1 (!master_clear)[*2]
		|-> ##1 pulseOut) else $error("falling trigger missed");
	AST_RETRIG:
	assert property (retrigger_sel[*3] ##0 ($rose(trigPos) && pulseOut)
		##1 (pulseOut && !master_clear)[*2] |-> ##1 pulseOut && countValue[7:0] <= 8'h01)
		else $error("retrigger did not restart");
	AST_HOLD:
	assert property ((!retrigger_sel)[*3] ##0 pulseOut ##1 pulseOut
		|-> countValue >= $past(countValue)) else $error("count restarted");
	AST_END:
	assert property ($fell(pulseOut) |-> !(|countValue) && pulseOutN) else $error("end not idle");
	AST_OSC_ON:
	assert property (pulseOut |-> oscEnable) else $error("oscillator off in pulse");
	AST_OSC_OFF:
	assert property ((!osc_run_sel)[*4] ##0 !pulseOut |-> !oscEnable) else $error("osc not off");
	AST_MIN:
	assert property ($rose(pulseOut) ##1 !master_clear |-> pulseOut || MIN_CYCLES < 2)
		else $error("pulse too short");
endmodule // pdm_timer_checker
bind pdm_timer pdm_timer_checker #(.MIN_CYCLES(MIN_CYCLES)) chk_u (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.trigPos(trigPos),
	.trigNeg(trigNeg),
	.retrigger_sel(retrigger_sel),
	.osc_run_sel(osc_run_sel),
	.master_clear(master_clear),
	.pulseOut(pulseOut),
	.pulseOutN(pulseOutN),
	.oscEnable(oscEnable),
	.countValue(countValue)
);

//--- tb/programmable_delay_monostable_tb.sv
// Self-checking bench of the delay timer with its oscillator model.
// Assumes the default pulse floor of two cycles.
`timescale 1ns/1ns
module programmable_delay_monostable_tb;
	import pdm_pkg::*;
	logic sys_clk = 1'b0, sys_rst = 1'b1, trigPos = 1'b0, trigNeg = 1'b1;
	logic retrigger_sel = 1'b0, osc_run_sel = 1'b0, range_sel = 1'b0, master_clear = 1'b0;
	logic stall = 1'b0, clkPrev = 1'b0, clock_osc_in, pulseOut, pulseOutN, oscEnable;
	logic [2:0] sel = 3'h0;
	logic [COUNT_W-1:0] countValue;
	int miscompares = 0, n_compared = 0, ticks = 0, tickBase = 0;
	always #25 sys_clk = ~sys_clk;
	pdm_osc_model osc_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .oscEnable(oscEnable),
		.stall(stall), .clock_osc_in(clock_osc_in));
	pdm_timer dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clock_osc_in(clock_osc_in),
		.trigPos(trigPos), .trigNeg(trigNeg), .retrigger_sel(retrigger_sel),
		.osc_run_sel(osc_run_sel), .range_sel(range_sel), .ratio_sel_0(sel[0]),
		.ratio_sel_1(sel[1]), .ratio_sel_2(sel[2]), .master_clear(master_clear),
		.pulseOut(pulseOut), .pulseOutN(pulseOutN), .oscEnable(oscEnable),
		.countValue(countValue));
	// Counting clock rises seen while the pulse stands
	always @(posedge sys_clk) begin
		clkPrev <= clock_osc_in;
		if (pulseOut && clock_osc_in && !clkPrev)
			ticks <= ticks + 1;
	end
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic fire(input logic neg);
		@(posedge sys_clk);
		if (neg)
			trigNeg <= 1'b0;
		else
			trigPos <= 1'b1;
		@(posedge sys_clk);
		trigNeg <= 1'b1;
		trigPos <= 1'b0;
	endtask
	task automatic wait_end();
		int i;
		for (i = 0; i < 5000 && pulseOut !== 1'b0; i++)
			@(negedge sys_clk);
		check("pulse end", i < 5000, 1);
		check("idle count", countValue, 0);
		check("idle qn", pulseOutN, 1);
		// Hand back on a rising edge so stimulus lands there
		@(posedge sys_clk);
	endtask
	// One pulse, optionally hit again after again cycles
	task automatic run(input logic neg, input int again);
		tickBase = ticks;
		fire(neg);
		cyc(2);
		@(negedge sys_clk);
		check("start q", {pulseOut, pulseOutN, oscEnable}, 3'b101);
		if (again > 0) begin
			cyc(again);
			fire(0);
		end
		wait_end();
	endtask
	task automatic final_report();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		#1000000;
		miscompares++;
		final_report();
	end
	initial begin
		cyc(6);
		@(negedge sys_clk) sys_rst <= 1'b0;
		cyc(3);
		check("reset outs", {pulseOut, pulseOutN, oscEnable, countValue}, 27'h2000000);
		for (int s = 0; s < 8; s++) begin
			sel <= 3'(s);
			cyc(3);
			run(0, 0);
			check("ratio", ticks - tickBase, 32'h1 << (s + 1));
		end
		sel <= 3'h3;
		run(1, 0);
		check("neg ratio", ticks - tickBase, 16);
		run(0, 20);
		check("no retrig", ticks - tickBase, 16);
		retrigger_sel <= 1'b1;
		cyc(3);
		run(0, 40);
		check("retrig", (ticks - tickBase) > 20 && (ticks - tickBase) < 32, 1);
		retrigger_sel <= 1'b0;
		sel <= 3'h7;
		fire(0);
		cyc(10);
		master_clear <= 1'b1;
		fire(0);
		cyc(3);
		check("clear outs", {pulseOut, pulseOutN, countValue}, 26'h1000000);
		@(negedge sys_clk) master_clear <= 1'b0;
		cyc(6);
		check("no late pulse", pulseOut, 0);
		tickBase = ticks;
		fire(0);
		for (int i = 0; i < 2000 && (ticks - tickBase) < 255; i++)
			@(negedge sys_clk);
		@(posedge sys_clk) stall <= 1'b1;
		range_sel <= 1'b1;
		cyc(5);
		check("preload", {pulseOut, countValue}, 25'h1ffffff);
		stall <= 1'b0;
		wait_end();
		check("one more tick", ticks - tickBase, 256);
		// Both triggers on one line: each edge of it fires
		range_sel <= 1'b0;
		sel <= 3'h1;
		cyc(3);
		tickBase = ticks;
		trigPos <= 1'b1;
		trigNeg <= 1'b1;
		cyc(4);
		wait_end();
		check("tied rise", ticks - tickBase, 4);
		tickBase = ticks;
		trigPos <= 1'b0;
		trigNeg <= 1'b0;
		cyc(4);
		wait_end();
		check("tied fall", ticks - tickBase, 4);
		trigNeg <= 1'b1;
		osc_run_sel <= 1'b1;
		cyc(4);
		check("osc free", oscEnable, 1);
		osc_run_sel <= 1'b0;
		cyc(4);
		check("osc gated", oscEnable, 0);
		final_report();
	end
endmodule // programmable_delay_monostable_tb
